// file: pssr_status_regs.sv
`timescale 1ns/1ps
`include "pssr_map.svh"
module pssr_status_regs
    import pssr_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Decoded host transactions
    input wire logic [7:0] cmd_in,
    input wire logic wr_byte_in,
    input wire logic [7:0] wr_data_in,
    input wire logic rd_in,
    input wire logic clear_faults_in,
    output logic [15:0] rd_data_out,
    output logic rd_valid_out,
    output logic invalid_out,
    // Live channel pins
    input wire logic chan_a_ready_pin_in,
    input wire logic chan_b_ready_pin_in,
    input wire logic [1:0] power_on_in,
    // Output-voltage conditions, index 0 is channel A
    input wire logic [1:0] out_overvoltage_fault_in,
    input wire logic [1:0] out_undervoltage_fault_in,
    input wire logic [1:0] out_limit_exceeded_warn_in,
    // Latched flags from the detailed registers kept elsewhere
    input wire logic [1:0] iout_any_flag_in,
    input wire logic [1:0] detail_overcurrent_flag_in,
    input wire logic [1:0] vendor_specific_fault_in,
    input wire logic [1:0] temp_flag_in,
    input wire logic [1:0] comm_mem_logic_fault_in,
    input wire logic [1:0] other_flag_in,
    input wire logic input_any_flag_in,
    input wire logic input_lockout_threshold_in
);
    logic [7:0] page;
    pssr_chan_t sel_chan;
    pssr_acc_t acc;
    logic [15:0] next_rd_data;
    logic wr_vout_a;
    logic wr_vout_b;
    logic [15:0] sum_a;
    logic [15:0] sum_b;
    logic [7:0] vout_a;
    logic [7:0] vout_b;
    logic [1:0] ready_pins;

    pssr_vout_if vif [2] ();

    // Summary word decode, pure logic with no storage
    function automatic logic [15:0] pssr_summary(
        input logic [7:0] vout,
        input logic ready,
        input logic pwr,
        input logic iout_any,
        input logic oc,
        input logic inp_any,
        input logic lockout,
        input logic vend,
        input logic temp,
        input logic comm_mem_logic_fault,
        input logic other
    );
        logic [15:0] s;
        s = 16'h0000;
        s[`PSSR_SW_VOUT] = |vout;
        s[`PSSR_SW_IOUT] = iout_any;
        s[`PSSR_SW_INPUT] = inp_any;
        s[`PSSR_SW_VEND] = vend;
        s[`PSSR_SW_PGOOD] = ~ready;
        s[`PSSR_SW_OFF] = ~pwr;
        s[`PSSR_SW_OV] = vout[`PSSR_VOUT_OV];
        s[`PSSR_SW_OC] = oc;
        s[`PSSR_SW_LOCK] = lockout;
        s[`PSSR_SW_TEMP] = temp;
        s[`PSSR_SW_CML] = comm_mem_logic_fault;
        // Under-voltage and limit warning have no bit of their own
        s[`PSSR_SW_OTHER] = other | vout[`PSSR_VOUT_UV] | vout[`PSSR_VOUT_LIM];
        return s;
    endfunction : pssr_summary

    assign ready_pins = {chan_b_ready_pin_in, chan_a_ready_pin_in};
    assign vout_a = vif[0].status;
    assign vout_b = vif[1].status;

    // Page B only on 01h; 00h and the all-pages value read channel A
    assign sel_chan = (page == `PSSR_PAGE_B) ? PSSR_CH_B : PSSR_CH_A;

    // Writes to the output-voltage register; all-pages hits both channels
    assign wr_vout_a = wr_byte_in && (cmd_in == `PSSR_CMD_VOUT) && (page != `PSSR_PAGE_B);
    assign wr_vout_b = wr_byte_in && (cmd_in == `PSSR_CMD_VOUT) && (page != `PSSR_PAGE_A);

    // Per-channel flag stores
    for (genvar g = 0; g < 2; g++) begin : g_chan
        logic wr_hit;
        assign wr_hit = (g == 0) ? wr_vout_a : wr_vout_b;
        assign vif[g].ov_cond = out_overvoltage_fault_in[g];
        assign vif[g].uv_cond = out_undervoltage_fault_in[g];
        assign vif[g].lim_event = out_limit_exceeded_warn_in[g];
        // One write clears detail and summary alike, since the summary is decoded
        assign vif[g].clear_mask = clear_faults_in ? 8'hff :
                                   (wr_hit ? wr_data_in : 8'h00);

        pssr_vout_latch u_latch (
            .sys_clk_in (sys_clk_in),
            .rst_n_in (rst_n_in),
            .vif (vif[g])
        );
    end

    // Summary for each channel
    assign sum_a = pssr_summary(vout_a, ready_pins[0], power_on_in[0], iout_any_flag_in[0],
                                detail_overcurrent_flag_in[0], input_any_flag_in,
                                input_lockout_threshold_in, vendor_specific_fault_in[0],
                                temp_flag_in[0], comm_mem_logic_fault_in[0], other_flag_in[0]);
    assign sum_b = pssr_summary(vout_b, ready_pins[1], power_on_in[1], iout_any_flag_in[1],
                                detail_overcurrent_flag_in[1], input_any_flag_in,
                                input_lockout_threshold_in, vendor_specific_fault_in[1],
                                temp_flag_in[1], comm_mem_logic_fault_in[1], other_flag_in[1]);

    // Transaction decode; a write wins over a read in the same cycle
    always_comb begin
        acc = PSSR_ACC_NONE;
        next_rd_data = 16'h0000;
        if (wr_byte_in) begin
            unique case (cmd_in)
                `PSSR_CMD_PAGE: begin
                    if (wr_data_in == `PSSR_PAGE_A || wr_data_in == `PSSR_PAGE_B ||
                        wr_data_in == `PSSR_PAGE_ALL) begin
                        acc = PSSR_ACC_OK;
                    end else begin
                        acc = PSSR_ACC_BAD;
                    end
                end
                `PSSR_CMD_VOUT: acc = PSSR_ACC_OK;
                // Summary word is read-only
                `PSSR_CMD_WORD: acc = PSSR_ACC_BAD;
                default: acc = PSSR_ACC_BAD;
            endcase
        end else if (rd_in) begin
            unique case (cmd_in)
                `PSSR_CMD_PAGE: begin
                    acc = PSSR_ACC_OK;
                    next_rd_data = {8'h00, page};
                end
                `PSSR_CMD_WORD: begin
                    acc = PSSR_ACC_OK;
                    next_rd_data = (sel_chan == PSSR_CH_B) ? sum_b : sum_a;
                end
                `PSSR_CMD_VOUT: begin
                    acc = PSSR_ACC_OK;
                    // Single byte in the low lane
                    next_rd_data = {8'h00, (sel_chan == PSSR_CH_B) ? vout_b : vout_a};
                end
                default: acc = PSSR_ACC_BAD;
            endcase
        end
    end

    // Page register, only legal values are stored
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            page <= `PSSR_PAGE_RST;
        end else if (wr_byte_in && cmd_in == `PSSR_CMD_PAGE && acc == PSSR_ACC_OK) begin
            page <= wr_data_in;
        end
    end

    // Read data held until the next good read
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_out <= 16'h0000;
        end else if (rd_in && !wr_byte_in && acc == PSSR_ACC_OK) begin
            rd_data_out <= next_rd_data;
        end
    end

    // Completion and refusal pulses
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_valid_out <= 1'b0;
            invalid_out <= 1'b0;
        end else begin
            rd_valid_out <= rd_in && !wr_byte_in && acc == PSSR_ACC_OK;
            invalid_out <= acc == PSSR_ACC_BAD;
        end
    end

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // Summary read returns any-vout flag of the selected channel
    AST_SUM_VOUT: assert property (
        (rd_in && !wr_byte_in && cmd_in == `PSSR_CMD_WORD)
        |=> rd_valid_out && rd_data_out[`PSSR_SW_VOUT] ==
            $past(sel_chan == PSSR_CH_B ? |vout_b : |vout_a))
        else $error("summary vout bit wrong");

    // Power-good bit is the inverted live pin
    AST_SUM_PGOOD: assert property (
        (rd_in && !wr_byte_in && cmd_in == `PSSR_CMD_WORD)
        |=> rd_data_out[`PSSR_SW_PGOOD] != $past(ready_pins[sel_chan]))
        else $error("summary power-good bit wrong");

    // Unsupported summary bits read zero
    AST_SUM_RSV: assert property (
        (rd_in && !wr_byte_in && cmd_in == `PSSR_CMD_WORD)
        |=> rd_data_out[`PSSR_SW_RSV_HI:`PSSR_SW_RSV_LO] == 4'h0)
        else $error("summary reserved bits not zero");

    // Off bit follows delivered power without latching
    AST_SUM_OFF: assert property (
        (rd_in && !wr_byte_in && cmd_in == `PSSR_CMD_WORD && power_on_in == 2'b11)
        |=> !rd_data_out[`PSSR_SW_OFF])
        else $error("off bit set while delivering power");

    // Over-voltage summary ties to channel A detail on page FFh
    AST_SUM_OV_ALL: assert property (
        (rd_in && !wr_byte_in && cmd_in == `PSSR_CMD_WORD && page == `PSSR_PAGE_ALL)
        |=> rd_data_out[`PSSR_SW_OV] == $past(vout_a[`PSSR_VOUT_OV]))
        else $error("page FFh did not read channel A");

    // Under-voltage shows up in the other-fault bit
    AST_SUM_OTHER: assert property (
        (rd_in && !wr_byte_in && cmd_in == `PSSR_CMD_WORD && vout_a[`PSSR_VOUT_UV] &&
         page == `PSSR_PAGE_A)
        |=> rd_data_out[`PSSR_SW_OTHER])
        else $error("under-voltage missing from other bit");

    // Summary write refused and nothing moves
    AST_WORD_WR_BAD: assert property (
        (wr_byte_in && cmd_in == `PSSR_CMD_WORD)
        |=> invalid_out && $stable(page) && !rd_valid_out)
        else $error("summary write not refused");

    // A condition latches its flag, which then holds while no clear arrives
    AST_OV_LATCH: assert property (
        (out_overvoltage_fault_in[0] ##1
         (!clear_faults_in && !(wr_vout_a && wr_data_in[`PSSR_VOUT_OV])))
        |-> vout_a[`PSSR_VOUT_OV] ##1 vout_a[`PSSR_VOUT_OV])
        else $error("over-voltage flag not held");

    // Writing one clears a flag whose condition is gone
    AST_UV_CLEAR: assert property (
        (wr_vout_a && wr_data_in[`PSSR_VOUT_UV] && !out_undervoltage_fault_in[0])
        |=> !vout_a[`PSSR_VOUT_UV])
        else $error("under-voltage flag not cleared");

    // Limit warning latches on its event
    AST_LIM_SET: assert property (
        out_limit_exceeded_warn_in[1] |=> vout_b[`PSSR_VOUT_LIM])
        else $error("limit warning not latched");

    // Unsupported detail bits never set
    AST_VOUT_RSV: assert property (
        (vout_a & 8'h67) == 8'h00 && (vout_b & 8'h67) == 8'h00)
        else $error("unsupported vout bit set");

    // Byte read carries nothing in the high lane
    AST_VOUT_BYTE: assert property (
        (rd_in && !wr_byte_in && cmd_in == `PSSR_CMD_VOUT)
        |=> rd_valid_out && rd_data_out[15:8] == 8'h00)
        else $error("vout read not one byte");

    // Current summary bit mirrors the selected channel's detail flag
    AST_SUM_IOUT: assert property (
        (rd_in && !wr_byte_in && cmd_in == `PSSR_CMD_WORD)
        |=> rd_data_out[`PSSR_SW_IOUT] == $past(iout_any_flag_in[sel_chan]))
        else $error("summary current bit wrong");

    // Input summary bit is shared by both channels
    AST_SUM_INPUT: assert property (
        (rd_in && !wr_byte_in && cmd_in == `PSSR_CMD_WORD)
        |=> rd_data_out[`PSSR_SW_INPUT] == $past(input_any_flag_in))
        else $error("summary input bit wrong");

    // Vendor summary bit mirrors the selected channel
    AST_SUM_VEND: assert property (
        (rd_in && !wr_byte_in && cmd_in == `PSSR_CMD_WORD)
        |=> rd_data_out[`PSSR_SW_VEND] == $past(vendor_specific_fault_in[sel_chan]))
        else $error("summary vendor bit wrong");

    // Off bit is raw and set whenever the channel is not powered
    AST_SUM_OFF_RAW: assert property (
        (rd_in && !wr_byte_in && cmd_in == `PSSR_CMD_WORD)
        |=> rd_data_out[`PSSR_SW_OFF] == $past(!power_on_in[sel_chan]))
        else $error("summary off bit wrong");

    // Over-current summary bit follows the detail fault flag
    AST_SUM_OC: assert property (
        (rd_in && !wr_byte_in && cmd_in == `PSSR_CMD_WORD)
        |=> rd_data_out[`PSSR_SW_OC] == $past(detail_overcurrent_flag_in[sel_chan]))
        else $error("summary over-current bit wrong");

    // Lockout summary bit follows the shared latched input flag
    AST_SUM_LOCK: assert property (
        (rd_in && !wr_byte_in && cmd_in == `PSSR_CMD_WORD)
        |=> rd_data_out[`PSSR_SW_LOCK] == $past(input_lockout_threshold_in))
        else $error("summary lockout bit wrong");

    // Temperature summary bit follows the selected channel
    AST_SUM_TEMP: assert property (
        (rd_in && !wr_byte_in && cmd_in == `PSSR_CMD_WORD)
        |=> rd_data_out[`PSSR_SW_TEMP] == $past(temp_flag_in[sel_chan]))
        else $error("summary temperature bit wrong");

    // Communication fault summary bit follows the selected channel
    AST_SUM_CML: assert property (
        (rd_in && !wr_byte_in && cmd_in == `PSSR_CMD_WORD)
        |=> rd_data_out[`PSSR_SW_CML] == $past(comm_mem_logic_fault_in[sel_chan]))
        else $error("summary comm fault bit wrong");

    // Page 01h reads the channel B byte
    AST_PAGE_B: assert property (
        (rd_in && !wr_byte_in && cmd_in == `PSSR_CMD_VOUT && page == `PSSR_PAGE_B)
        |=> rd_data_out[7:0] == $past(vout_b))
        else $error("page 01h did not read channel B");

    // Illegal page values are refused and the page holds
    AST_PAGE_KEEP: assert property (
        (wr_byte_in && cmd_in == `PSSR_CMD_PAGE && wr_data_in != `PSSR_PAGE_A &&
         wr_data_in != `PSSR_PAGE_B && wr_data_in != `PSSR_PAGE_ALL)
        |=> invalid_out && $stable(page))
        else $error("illegal page value taken");

    // Limit warning clears on a write of one once its event is gone
    AST_LIM_CLEAR: assert property (
        (wr_vout_b && wr_data_in[`PSSR_VOUT_LIM] && !out_limit_exceeded_warn_in[1])
        |=> !vout_b[`PSSR_VOUT_LIM])
        else $error("limit warning not cleared");

    // Global clear drops the over-voltage flag of both channels when no over-voltage persists
    AST_GLOBAL_CLEAR: assert property (
        (clear_faults_in && out_overvoltage_fault_in == 2'b00)
        |=> !vout_a[`PSSR_VOUT_OV] && !vout_b[`PSSR_VOUT_OV])
        else $error("global clear left a flag set");

    // A transaction is either answered or refused, never both
    AST_ONE_ANSWER: assert property (
        !(rd_valid_out && invalid_out))
        else $error("read answered and refused together");
endmodule : pssr_status_regs

// file: pssr_map.svh
// Overview of operation
// - Summary bit 15 is set while any output-voltage flag is latched.
// - Summary bit 14 is set while any output-current flag is latched.
// - Summary bit 13 is set while any input voltage or current flag is latched.
// - Summary bit 12 is set while any vendor-specific fault flag is latched.
// - Summary bits 10 down to 7 always read zero.
// - Summary bit 6 is a live flag, high while no output power is delivered.
// - Summary bit 5 follows the latched output over-voltage fault.
// - Summary bit 4 follows the latched output over-current fault.
// - Summary bit 3 follows the latched input lockout condition.
// - Summary bit 2 follows the latched over-temperature fault or warning.
// - Summary bit 1 follows the latched communication, memory or logic fault.
// - Summary bit 0 shows any other latched fault, such as output under-voltage.
// - The summary word stores nothing; it is decoded from detailed flags.
// - Writing one to a detailed bit clears it and its summary bit together.
// - Writes to the summary word are invalid and change nothing.
// - The output-voltage status register reads back as one byte.
// - Page 00h selects channel A, 01h channel B, FFh reads channel A.
// - Flags latch on their condition and hold until cleared by command or write.
// - Output-voltage bit 7 latches over-voltage, bit 4 under-voltage, bit 3 the limit warning, others zero.
// - Writing one to a supported bit clears it unless the condition persists.
`ifndef PSSR_MAP_SVH
`define PSSR_MAP_SVH
// Command codes
`define PSSR_CMD_PAGE 8'h00
`define PSSR_CMD_WORD 8'h79
`define PSSR_CMD_VOUT 8'h7a
// Page values
`define PSSR_PAGE_A 8'h00
`define PSSR_PAGE_B 8'h01
`define PSSR_PAGE_ALL 8'hff
`define PSSR_PAGE_RST 8'h00
// Output-voltage status fields
`define PSSR_VOUT_OV 7
`define PSSR_VOUT_UV 4
`define PSSR_VOUT_LIM 3
`define PSSR_VOUT_RST 8'h00
// Summary word fields
`define PSSR_SW_VOUT 15
`define PSSR_SW_IOUT 14
`define PSSR_SW_INPUT 13
`define PSSR_SW_VEND 12
`define PSSR_SW_PGOOD 11
`define PSSR_SW_RSV_HI 10
`define PSSR_SW_RSV_LO 7
`define PSSR_SW_OFF 6
`define PSSR_SW_OV 5
`define PSSR_SW_OC 4
`define PSSR_SW_LOCK 3
`define PSSR_SW_TEMP 2
`define PSSR_SW_CML 1
`define PSSR_SW_OTHER 0
`endif

// file: pssr_pkg.sv
package pssr_pkg;
    // Channel selected by the page setting
    typedef enum logic {PSSR_CH_A, PSSR_CH_B} pssr_chan_t;
    // Outcome of one host transaction
    typedef enum logic [1:0] {PSSR_ACC_NONE, PSSR_ACC_OK, PSSR_ACC_BAD} pssr_acc_t;
endpackage : pssr_pkg

// file: pssr_vout_if.sv
`timescale 1ns/1ps
interface pssr_vout_if;
    logic ov_cond;
    logic uv_cond;
    logic lim_event;
    logic [7:0] clear_mask;
    logic [7:0] status;
    // Flag store side
    modport latch (input ov_cond, input uv_cond, input lim_event, input clear_mask,
                   output status);
    // Decoder side
    modport ctrl (output ov_cond, output uv_cond, output lim_event, output clear_mask,
                  input status);
endinterface : pssr_vout_if

// file: pssr_vout_latch.sv
`timescale 1ns/1ps
`include "pssr_map.svh"
module pssr_vout_latch
    import pssr_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Flag traffic
    pssr_vout_if.latch vif
);
    logic ov_q;
    logic uv_q;
    logic lim_q;

    // Set beats clear so a fresh or persisting condition is never lost
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ov_q <= 1'b0;
        end else begin
            ov_q <= vif.ov_cond | (ov_q & ~vif.clear_mask[`PSSR_VOUT_OV]);
        end
    end

    // Under-voltage flag
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            uv_q <= 1'b0;
        end else begin
            uv_q <= vif.uv_cond | (uv_q & ~vif.clear_mask[`PSSR_VOUT_UV]);
        end
    end

    // Limit warning, set by each refused voltage request
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lim_q <= 1'b0;
        end else begin
            lim_q <= vif.lim_event | (lim_q & ~vif.clear_mask[`PSSR_VOUT_LIM]);
        end
    end

    // Unsupported positions tied low
    always_comb begin
        vif.status = `PSSR_VOUT_RST;
        vif.status[`PSSR_VOUT_OV] = ov_q;
        vif.status[`PSSR_VOUT_UV] = uv_q;
        vif.status[`PSSR_VOUT_LIM] = lim_q;
    end
endmodule : pssr_vout_latch

// file: pssr_host.sv
`timescale 1ns/1ps
module pssr_host (
    // Clock
    input wire logic sys_clk_in,
    // Transaction strobes towards the device
    output logic [7:0] cmd_out,
    output logic wr_byte_out,
    output logic [7:0] wr_data_out,
    output logic rd_out,
    output logic clear_faults_out
);
    // Idle bus at time zero
    initial begin
        cmd_out = 8'h00;
        wr_byte_out = 1'b0;
        wr_data_out = 8'h00;
        rd_out = 1'b0;
        clear_faults_out = 1'b0;
    end

    // One byte write, byte read or word read per call, never a block access
    task automatic xfer(input logic wr, input logic [7:0] cmd, input logic [7:0] data);
        @(posedge sys_clk_in);
        #1;
        cmd_out = cmd;
        wr_data_out = wr ? data : ~wr_data_out; // Reads drive the inverted idle value, which is the previous transfer's data
        wr_byte_out = wr;
        rd_out = ~wr;
        @(posedge sys_clk_in);
        #1;
        wr_byte_out = 1'b0;
        rd_out = 1'b0;
        cmd_out = ~cmd; // Idle command is meaningless without a strobe
        wr_data_out = ~wr_data_out;
    endtask : xfer

    // Global clear of latched flags, one cycle wide
    task automatic clear_all();
        @(posedge sys_clk_in);
        #1;
        clear_faults_out = 1'b1;
        @(posedge sys_clk_in);
        #1;
        clear_faults_out = 1'b0;
    endtask : clear_all
endmodule : pssr_host

// file: pssr_status_regs_bench.sv
`timescale 1ns/1ps
`include "pssr_map.svh"
module pssr_status_regs_bench;
    import pssr_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] cmd, wr_data;
    logic wr_byte, rd, clr;
    logic [15:0] rd_data;
    logic rd_valid, invalid;
    logic rdy_a = 1'b1, rdy_b = 1'b1, inp_any = 1'b0, lockout = 1'b0;
    logic [1:0] pwr = 2'b11, ov = 2'b00, uv = 2'b00, lim = 2'b00;
    logic [1:0] iout = 2'b00, oc = 2'b00, vend = 2'b00, temp = 2'b00, comm_mem_logic_fault = 2'b00, oth = 2'b00;
    logic [7:0] vf [2];
    logic [16:0] exp_q [$];
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;

    // Clock at 10 MHz
    always #50 sys_clk = ~sys_clk;

    pssr_host i_pssr_host (.sys_clk_in(sys_clk), .cmd_out(cmd), .wr_byte_out(wr_byte),
        .wr_data_out(wr_data), .rd_out(rd), .clear_faults_out(clr));

    pssr_status_regs i_pssr_status_regs (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .cmd_in(cmd),
        .wr_byte_in(wr_byte), .wr_data_in(wr_data), .rd_in(rd), .clear_faults_in(clr),
        .rd_data_out(rd_data), .rd_valid_out(rd_valid), .invalid_out(invalid),
        .chan_a_ready_pin_in(rdy_a), .chan_b_ready_pin_in(rdy_b), .power_on_in(pwr),
        .out_overvoltage_fault_in(ov), .out_undervoltage_fault_in(uv),
        .out_limit_exceeded_warn_in(lim), .iout_any_flag_in(iout),
        .detail_overcurrent_flag_in(oc), .vendor_specific_fault_in(vend), .temp_flag_in(temp),
        .comm_mem_logic_fault_in(comm_mem_logic_fault), .other_flag_in(oth), .input_any_flag_in(inp_any),
        .input_lockout_threshold_in(lockout));

    task automatic check(input logic [16:0] seen, input logic [16:0] expv);
        comparisons++;
        if (seen !== expv) begin
            n_mismatch++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, expv);
        end
    endtask : check

    task automatic close_out();
        $display("counts: %0d compared, %0d mismatched", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out

    // Expected summary word, rebuilt from the inputs and the tracked vout flags
    function automatic logic [15:0] exp_word(input int ch);
        logic [15:0] w;
        w = 16'h0000; // Bits 10 to 7 stay zero
        w[15] = |vf[ch];
        w[14] = iout[ch];
        w[13] = inp_any;
        w[12] = vend[ch];
        w[11] = ~(ch == 1 ? rdy_b : rdy_a);
        w[6] = ~pwr[ch];
        w[5] = vf[ch][7];
        w[4] = oc[ch];
        w[3] = lockout;
        w[2] = temp[ch];
        w[1] = comm_mem_logic_fault[ch];
        w[0] = oth[ch] | vf[ch][4] | vf[ch][3];
        return w;
    endfunction : exp_word

    // Note the expected answer, then issue the transaction
    task automatic rdx(input logic [7:0] c, input logic [15:0] e);
        exp_q.push_back({1'b0, e});
        i_pssr_host.xfer(1'b0, c, 8'h00);
    endtask : rdx

    task automatic wrx(input logic [7:0] c, input logic [7:0] d, input logic bad);
        if (bad) begin
            exp_q.push_back({1'b1, 16'h0000});
        end
        i_pssr_host.xfer(1'b1, c, d);
    endtask : wrx

    // One-cycle vout condition on a channel; flag is then expected latched
    task automatic pulse(input int ch, input int b);
        @(posedge sys_clk);
        #1;
        if (b == 7) ov[ch] = 1'b1;
        else if (b == 4) uv[ch] = 1'b1;
        else lim[ch] = 1'b1;
        @(posedge sys_clk);
        #1;
        ov = 2'b00;
        uv = 2'b00;
        lim = 2'b00;
        vf[ch][b] = 1'b1;
    endtask : pulse

    // Scoreboard: every answer pulse takes the oldest note
    always @(posedge sys_clk) begin
        #5;
        if (rd_valid === 1'b1 || invalid === 1'b1) begin
            if (exp_q.size() == 0) check({invalid, rd_data}, ~{invalid, rd_data});
            else check({invalid, invalid ? 16'h0000 : rd_data}, exp_q.pop_front());
        end
    end

    // Hang guard, well above the few hundred cycles the run needs
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 4000) begin
            n_mismatch++;
            close_out();
        end
    end

    initial begin
        logic [7:0] pg [3];
        pg = '{8'h00, 8'h01, 8'hff};
        vf = '{8'h00, 8'h00};
        repeat (20) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        void'($urandom(44));
        rdx(`PSSR_CMD_PAGE, 16'h0000);
        rdx(`PSSR_CMD_VOUT, 16'h0000);
        rdx(`PSSR_CMD_WORD, exp_word(0));
        $display("test reset values done");
        // Random live pins and detail flags, read through every page
        for (int i = 0; i < 12; i++) begin
            {iout, oc, vend, temp, comm_mem_logic_fault, oth} = 12'($urandom());
            {rdy_a, rdy_b, inp_any, lockout, pwr} = 6'($urandom());
            for (int p = 0; p < 3; p++) begin
                wrx(`PSSR_CMD_PAGE, pg[p], 1'b0);
                rdx(`PSSR_CMD_WORD, exp_word(pg[p] == 8'h01 ? 1 : 0));
                rdx(`PSSR_CMD_PAGE, {8'h00, pg[p]});
            end
        end
        $display("test summary mapping done");
        wrx(`PSSR_CMD_PAGE, 8'h01, 1'b0); // Loop left the page at FFh, which reads channel A
        pulse(1, 7);
        rdx(`PSSR_CMD_VOUT, 16'h0080);
        rdx(`PSSR_CMD_WORD, exp_word(1));
        wrx(`PSSR_CMD_PAGE, 8'h00, 1'b0);
        pulse(0, 4);
        pulse(0, 3);
        rdx(`PSSR_CMD_VOUT, 16'h0018);
        rdx(`PSSR_CMD_WORD, exp_word(0));
        wrx(`PSSR_CMD_VOUT, 8'h67, 1'b0);
        rdx(`PSSR_CMD_VOUT, 16'h0018);
        uv[0] = 1'b1;
        wrx(`PSSR_CMD_VOUT, 8'h10, 1'b0);
        rdx(`PSSR_CMD_VOUT, 16'h0018);
        uv[0] = 1'b0;
        wrx(`PSSR_CMD_VOUT, 8'h18, 1'b0);
        vf[0] = 8'h00;
        rdx(`PSSR_CMD_WORD, exp_word(0));
        $display("test vout latch and clear done");
        wrx(`PSSR_CMD_WORD, 8'hff, 1'b1);
        wrx(`PSSR_CMD_PAGE, 8'h02, 1'b1);
        wrx(8'h55, 8'h00, 1'b1);
        rdx(`PSSR_CMD_PAGE, 16'h0000);
        rdx(8'h55, 16'h0000);
        exp_q[$] = {1'b1, 16'h0000};
        rdx(`PSSR_CMD_WORD, exp_word(0));
        $display("test refusals done");
        pulse(0, 7);
        pulse(1, 3);
        wrx(`PSSR_CMD_PAGE, 8'hff, 1'b0);
        rdx(`PSSR_CMD_VOUT, 16'h0080);
        wrx(`PSSR_CMD_VOUT, 8'h88, 1'b0);
        vf = '{8'h00, 8'h00};
        wrx(`PSSR_CMD_PAGE, 8'h01, 1'b0);
        rdx(`PSSR_CMD_VOUT, 16'h0000);
        pulse(0, 4);
        pulse(1, 7);
        i_pssr_host.clear_all();
        vf = '{8'h00, 8'h00};
        rdx(`PSSR_CMD_WORD, exp_word(1));
        wrx(`PSSR_CMD_PAGE, 8'h00, 1'b0);
        rdx(`PSSR_CMD_VOUT, 16'h0000);
        $display("test broadcast page and global clear done");
        repeat (3) @(posedge sys_clk);
        check(17'(exp_q.size()), 17'h0);
        close_out();
    end
endmodule : pssr_status_regs_bench
